// file: common/rgs_defines.svh
// Timing constants for the remote gauge switch control block
`ifndef RGS_DEFINES_SVH
`define RGS_DEFINES_SVH
`define RGS_CLK_MHZ 250
`define RGS_DEBOUNCE_MS 50
`define RGS_DEBOUNCE_CYC (`RGS_DEBOUNCE_MS * 1000 * `RGS_CLK_MHZ)
`define RGS_HOLDOFF_S 5
`define RGS_HOLDOFF_CYC (`RGS_HOLDOFF_S * 1000000 * `RGS_CLK_MHZ)
`endif

// file: common/rgs_pkg.sv
// Types shared by the remote gauge switch control block
package rgs_pkg;
  typedef struct packed {
    logic fil_first;
    logic degas_first;
    logic fil_second;
    logic degas_second;
  } rgs_req_t;
  typedef enum logic [1:0] {
    RGS_IDLE = 2'b00,
    RGS_LOW_WAIT = 2'b01,
    RGS_LOW = 2'b10
  } rgs_db_st_t;
endpackage : rgs_pkg

// file: hw/rgs_debounce.sv
// Synchroniser and debouncer for one active-low remote input
`timescale 1ns/1ps
`include "rgs_defines.svh"
module rgs_debounce #(
  parameter int unsigned DEB_CYC = `RGS_DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_n,
  output logic level_q,
  output logic fall_q
);
  logic [2:0] sync_q;
  logic [31:0] cnt_q;
  wire stable = (sync_q[2] == sync_q[1]);
  wire differs = stable && (sync_q[2] != level_q);
  wire expired = differs && (cnt_q >= DEB_CYC);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 3'h7;
      cnt_q <= 32'h0;
      level_q <= 1'b1;
      fall_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], pin_n};
      cnt_q <= differs && !expired ? cnt_q + 32'h1 : 32'h0;
      if (expired) begin
        level_q <= sync_q[2];
      end
      fall_q <= expired && !sync_q[2];
    end
  end
endmodule : rgs_debounce

// file: hw/rgs_top.sv
// Remote filament and degas switch control for two ionization gauges
`timescale 1ns/1ps
`include "rgs_defines.svh"
module rgs_top #(
  parameter int unsigned DEB_CYC = `RGS_DEBOUNCE_CYC,
  parameter int unsigned HOLD_CYC = `RGS_HOLDOFF_CYC
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic FIL_FIRST_N,
  input wire logic DEGAS_FIRST_N,
  input wire logic FIL_SECOND_N,
  input wire logic DEGAS_SECOND_N,
  input wire logic [1:0] PRESS_BELOW_LIMIT,
  input wire logic SINGLE_ELECTROMETER_UNIT,
  output logic [1:0] FIL_ON,
  output logic [1:0] DEGAS_ON,
  output logic [1:0] STATUS_RELAY
);
  logic [1:0] rst_sync_q;
  wire rst_n = rst_sync_q[1];
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  rgs_pkg::rgs_req_t pins_n, lvl, fall;
  assign pins_n = '{FIL_FIRST_N, DEGAS_FIRST_N, FIL_SECOND_N, DEGAS_SECOND_N};

  // One debouncer per input; level re-arms only after a debounced high
  for (genvar i = 0; i < 4; i++) begin : g_in
    rgs_debounce #(.DEB_CYC(DEB_CYC)) u_db (
      .clk(CLK),
      .rst_n(rst_n),
      .pin_n(pins_n[i]),
      .level_q(lvl[i]),
      .fall_q(fall[i])
    );
  end

  logic [1:0] fil_q, degas_q, ready_q;
  logic [31:0] hold_q [2];
  wire [1:0] fil_fall = {fall.fil_second, fall.fil_first};
  wire [1:0] dg_fall = {fall.degas_second, fall.degas_first};

  // Comparator and strap are asynchronous: three flops, take a value once the last two agree
  logic [1:0] prs_s1_q, prs_s2_q, prs_s3_q, press_ok_q;
  logic [2:0] single_s_q;
  logic single_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      prs_s1_q <= 2'h0;
      prs_s2_q <= 2'h0;
      prs_s3_q <= 2'h0;
      press_ok_q <= 2'h0;
      single_s_q <= 3'h7;
      single_q <= 1'b1;
    end else begin
      prs_s1_q <= PRESS_BELOW_LIMIT;
      prs_s2_q <= prs_s1_q;
      prs_s3_q <= prs_s2_q;
      // Bits that disagree keep their old value
      press_ok_q <= (prs_s2_q & prs_s3_q) | (press_ok_q & (prs_s2_q | prs_s3_q));
      single_s_q <= {single_s_q[1:0], SINGLE_ELECTROMETER_UNIT};
      if (single_s_q[2] == single_s_q[1]) begin
        single_q <= single_s_q[2];
      end
    end
  end

  // Filament on only if the other gauge is off on a single-electrometer unit
  wire [1:0] fil_ok = single_q ? {~fil_q[0], ~fil_q[1]} : 2'h3;
  // Degas validity sampled only at the edge itself
  wire [1:0] dg_ok = fil_q & ready_q & press_ok_q & {~degas_q[0], ~degas_q[1]};
  wire [1:0] fil_tgl = fil_fall & (fil_q | fil_ok);
  // Two starts in one cycle on a single unit: first gauge wins
  wire [1:0] fil_start = fil_tgl & ~fil_q & {~(single_q & fil_tgl[0] & ~fil_q[0]), 1'b1};
  wire [1:0] fil_nxt = (fil_q & ~fil_tgl) | fil_start;
  wire [1:0] dg_tgl = dg_fall & (degas_q | dg_ok);
  // Guard both degas starting together; first gauge wins
  wire [1:0] dg_start = dg_tgl & ~degas_q & {~(dg_tgl[0] & ~degas_q[0]), 1'b1};
  wire [1:0] dg_nxt = ((degas_q & ~dg_tgl) | dg_start) & fil_nxt;

  for (genvar g = 0; g < 2; g++) begin : g_gauge
    always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
        hold_q[g] <= 32'h0;
        ready_q[g] <= 1'b0;
      end else if (!fil_nxt[g]) begin
        hold_q[g] <= 32'h0;
        ready_q[g] <= 1'b0;
      end else if (!ready_q[g]) begin
        hold_q[g] <= hold_q[g] + 32'h1;
        ready_q[g] <= (hold_q[g] + 32'h1 >= HOLD_CYC);
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      fil_q <= 2'h0;
      degas_q <= 2'h0;
      FIL_ON <= 2'h0;
      DEGAS_ON <= 2'h0;
      STATUS_RELAY <= 2'h0;
    end else begin
      fil_q <= fil_nxt;
      degas_q <= dg_nxt;
      FIL_ON <= fil_nxt;
      DEGAS_ON <= dg_nxt;
      STATUS_RELAY <= fil_nxt;
    end
  end

  property p_relay;
    @(posedge CLK) disable iff (!rst_n) STATUS_RELAY == fil_q;
  endproperty
  a_relay: assert property (p_relay) else $error("relay differs from filament");
  property p_no_dual_degas;
    @(posedge CLK) disable iff (!rst_n) !(degas_q[0] && degas_q[1]);
  endproperty
  a_no_dual_degas: assert property (p_no_dual_degas) else $error("both gauges degas");
  property p_degas_needs_fil;
    @(posedge CLK) disable iff (!rst_n) degas_q[0] |-> fil_q[0];
  endproperty
  a_degas_needs_fil: assert property (p_degas_needs_fil) else $error("degas without filament");
  property p_degas_holdoff;
    @(posedge CLK) disable iff (!rst_n) $rose(degas_q[1]) |-> $past(ready_q[1] && press_ok_q[1]);
  endproperty
  a_degas_holdoff: assert property (p_degas_holdoff) else $error("degas began invalid");
  property p_single;
    @(posedge CLK) disable iff (!rst_n) single_q && fil_q[0] && !fil_q[1] |=> !fil_q[1];
  endproperty
  a_single: assert property (p_single) else $error("second gauge on with first");
  property p_toggle_cause;
    @(posedge CLK) disable iff (!rst_n) $changed(fil_q[0]) |-> $past(fall.fil_first);
  endproperty
  a_toggle_cause: assert property (p_toggle_cause) else $error("filament changed without edge");
  property p_fil_toggle;
    @(posedge CLK) disable iff (!rst_n) fall.fil_first && fil_q[0] |=> !fil_q[0];
  endproperty
  a_fil_toggle: assert property (p_fil_toggle) else $error("filament off request lost");
  property p_degas_off;
    @(posedge CLK) disable iff (!rst_n) fall.degas_first && degas_q[0] |=> !degas_q[0] && !DEGAS_ON[0];
  endproperty
  a_degas_off: assert property (p_degas_off) else $error("degas not removed");

  // Checks above repeated for the other gauge; outputs track state
  property p_outputs_match;
    @(posedge CLK) disable iff (!rst_n) FIL_ON == fil_q && DEGAS_ON == degas_q;
  endproperty
  a_outputs_match: assert property (p_outputs_match) else $error("outputs differ from state");
  property p_degas_needs_fil_second;
    @(posedge CLK) disable iff (!rst_n) degas_q[1] |-> fil_q[1];
  endproperty
  a_degas_needs_fil_second: assert property (p_degas_needs_fil_second) else $error("degas without filament");
  property p_degas_holdoff_first;
    @(posedge CLK) disable iff (!rst_n) $rose(degas_q[0]) |-> $past(ready_q[0]);
  endproperty
  a_degas_holdoff_first: assert property (p_degas_holdoff_first) else $error("degas began in hold-off");
  property p_degas_press;
    @(posedge CLK) disable iff (!rst_n) $rose(degas_q[0]) |-> $past(press_ok_q[0] && fil_q[0]);
  endproperty
  a_degas_press: assert property (p_degas_press) else $error("degas began above limit");
  property p_single_second;
    @(posedge CLK) disable iff (!rst_n) single_q && fil_q[1] && !fil_q[0] |=> !fil_q[0];
  endproperty
  a_single_second: assert property (p_single_second) else $error("first gauge on with second");
  property p_toggle_cause_second;
    @(posedge CLK) disable iff (!rst_n) $changed(fil_q[1]) |-> $past(fall.fil_second);
  endproperty
  a_toggle_cause_second: assert property (p_toggle_cause_second) else $error("filament changed without edge");
  property p_fil_toggle_second;
    @(posedge CLK) disable iff (!rst_n) fall.fil_second && fil_q[1] |=> !fil_q[1];
  endproperty
  a_fil_toggle_second: assert property (p_fil_toggle_second) else $error("filament off request lost");
  property p_degas_off_second;
    @(posedge CLK) disable iff (!rst_n) fall.degas_second && degas_q[1] |=> !degas_q[1] && !DEGAS_ON[1];
  endproperty
  a_degas_off_second: assert property (p_degas_off_second) else $error("degas not removed");

  // Degas only starts from its own edge, never later
  property p_degas_cause;
    @(posedge CLK) disable iff (!rst_n) $rose(degas_q[0]) |-> $past(fall.degas_first);
  endproperty
  a_degas_cause: assert property (p_degas_cause) else $error("degas began without edge");
  property p_degas_cause_second;
    @(posedge CLK) disable iff (!rst_n) $rose(degas_q[1]) |-> $past(fall.degas_second);
  endproperty
  a_degas_cause_second: assert property (p_degas_cause_second) else $error("degas began without edge");
  property p_fil_off_ends_degas;
    @(posedge CLK) disable iff (!rst_n) $fell(fil_q[0]) |-> !degas_q[0];
  endproperty
  a_fil_off_ends_degas: assert property (p_fil_off_ends_degas) else $error("degas outlived filament");
  property p_holdoff_restart;
    @(posedge CLK) disable iff (!rst_n) !fil_q[0] |-> !ready_q[0];
  endproperty
  a_holdoff_restart: assert property (p_holdoff_restart) else $error("hold-off not restarted");
  property p_ready_needs_fil;
    @(posedge CLK) disable iff (!rst_n) ready_q[1] |-> fil_q[1];
  endproperty
  a_ready_needs_fil: assert property (p_ready_needs_fil) else $error("hold-off done while off");

  // A fall pulse lasts one cycle, so one low level acts once
  property p_fall_pulse;
    @(posedge CLK) disable iff (!rst_n) fall.fil_first |=> !fall.fil_first;
  endproperty
  a_fall_pulse: assert property (p_fall_pulse) else $error("request acted twice");
  property p_fall_pulse_degas;
    @(posedge CLK) disable iff (!rst_n) fall.degas_second |=> !fall.degas_second;
  endproperty
  a_fall_pulse_degas: assert property (p_fall_pulse_degas) else $error("request acted twice");
endmodule : rgs_top

// file: verification/rgs_remote_partner.sv
// Automation-side model driving the active-low remote request pins
`timescale 1ns/1ps
module rgs_remote_partner (
  input wire rgs_pkg::rgs_req_t req,
  output logic [3:0] pin_n
);
  // Released pins sit at the pull-up level
  assign pin_n = ~req;
endmodule : rgs_remote_partner

// file: verification/rgs_top_test.sv
// Self-checking bench for the remote gauge switch control
`timescale 1ns/1ps
module rgs_top_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  rgs_pkg::rgs_req_t req = '0;
  logic [3:0] pin_n;
  logic [1:0] press_ok = 2'h0;
  logic single_unit = 1'b1;
  logic [1:0] fil_on;
  logic [1:0] degas_on;
  logic [1:0] relay;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  rgs_remote_partner i_rgs_remote_partner (.req(req), .pin_n(pin_n));
  rgs_top #(.DEB_CYC(20), .HOLD_CYC(200)) i_rgs_top (.CLK(clk), .RESET_N(rst_n), .FIL_FIRST_N(pin_n[3]),
    .DEGAS_FIRST_N(pin_n[2]), .FIL_SECOND_N(pin_n[1]), .DEGAS_SECOND_N(pin_n[0]), .PRESS_BELOW_LIMIT(press_ok),
    .SINGLE_ELECTROMETER_UNIT(single_unit), .FIL_ON(fil_on), .DEGAS_ON(degas_on), .STATUS_RELAY(relay));
  task automatic stop_test;
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Low phase, then a high phase long enough to re-arm the input
  task automatic press(input int idx, input int low_len);
    req[idx] <= 1'b1;
    repeat (low_len) @(posedge clk);
    req[idx] <= 1'b0;
    repeat (40) @(posedge clk);
  endtask : press
  task automatic t_fil_on;
    press(3, 40);
    chk(fil_on, 2'h1);
    chk(relay, 2'h1);
  endtask : t_fil_on
  task automatic t_degas_early;
    press_ok <= 2'h3;
    press(2, 40);
    chk(degas_on, 2'h0);
  endtask : t_degas_early
  task automatic t_glitch;
    press(3, 10);
    chk(fil_on, 2'h1);
  endtask : t_glitch
  task automatic t_single;
    press(1, 40);
    chk(fil_on, 2'h1);
    press(0, 40);
    chk(degas_on, 2'h0);
  endtask : t_single
  task automatic t_degas;
    press_ok <= 2'h0;
    press(2, 40);
    chk(degas_on, 2'h0);
    press_ok <= 2'h3;
    press(2, 40);
    chk(degas_on, 2'h1);
  endtask : t_degas
  task automatic t_fil_off;
    press(3, 100);
    chk(fil_on | degas_on, 2'h0);
    press(3, 40);
    press(2, 40);
    chk(degas_on, 2'h0);
    repeat (200) @(posedge clk);
    chk(degas_on, 2'h0);
  endtask : t_fil_off
  // Dual-electrometer unit: both filaments, one degas at a time
  task automatic t_dual;
    single_unit <= 1'b0;
    press(1, 40);
    chk(fil_on, 2'h3);
    chk(relay, 2'h3);
    repeat (200) @(posedge clk);
    press(0, 40);
    chk(degas_on, 2'h2);
    press(2, 40);
    chk(degas_on, 2'h2);
    press(1, 40);
    chk(fil_on, 2'h1);
    chk(degas_on, 2'h0);
  endtask : t_dual
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(fil_on | degas_on, 2'h0);
    t_fil_on();
    t_degas_early();
    t_glitch();
    t_single();
    t_degas();
    t_fil_off();
    t_dual();
    stop_test();
  end
  // Whole sequence needs about 1560 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count++;
      stop_test();
    end
  end
endmodule : rgs_top_test
